// *** hdl/scdc_pkg.sv ***
package scdc_pkg;

    localparam int          CLK_MHZ        = 40;
    localparam int          OFF_US_00      = 9;
    localparam int          OFF_US_01      = 19;
    localparam int          OFF_US_10      = 27;
    localparam int          OFF_US_11      = 35;
    localparam logic [10:0] OFF_CYC_00     = 11'(OFF_US_00 * CLK_MHZ);
    localparam logic [10:0] OFF_CYC_01     = 11'(OFF_US_01 * CLK_MHZ);
    localparam logic [10:0] OFF_CYC_10     = 11'(OFF_US_10 * CLK_MHZ);
    localparam logic [10:0] OFF_CYC_11     = 11'(OFF_US_11 * CLK_MHZ);
    localparam int          DYN_SHORT_NS   = 1000;
    localparam int          DYN_LONG_NS    = 10000;
    localparam logic [10:0] DYN_SHORT_CYC  = 11'((DYN_SHORT_NS * CLK_MHZ + 999) / 1000);
    localparam logic [10:0] DYN_LONG_CYC   = 11'((DYN_LONG_NS * CLK_MHZ) / 1000);

    localparam logic [3:0]  SHARE_MAX      = 4'hA;
    localparam logic [3:0]  SHARE_RST      = 4'h3;
    localparam logic [3:0]  MIX30_TENTHS   = 4'h3;
    localparam logic [3:0]  MIX60_TENTHS   = 4'h6;
    localparam logic [14:0] TENTHS_DIV     = 15'h000A;

    localparam logic [11:0] INT_REF_MV     = 12'hCE4;
    localparam logic [4:0]  RIPPLE_BASE_MA = 5'h19;
    localparam logic [2:0]  RIPPLE_PCT_00  = 3'h1;
    localparam logic [2:0]  RIPPLE_PCT_01  = 3'h2;
    localparam logic [2:0]  RIPPLE_PCT_10  = 3'h4;
    localparam logic [2:0]  RIPPLE_PCT_11  = 3'h6;

    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_SCALE     = 8'h04;
    localparam logic [7:0]  ADDR_STATUS    = 8'h08;
    localparam int          CTRL_INT_REF   = 0;
    localparam int          CTRL_EN        = 1;
    localparam int          CTRL_DECAY_LSB = 2;
    localparam int          CTRL_OFF_LSB   = 5;
    localparam int          CTRL_RIP_LSB   = 7;
    localparam int          SCALE_FS_LSB   = 0;
    localparam int          SCALE_HOLD_LSB = 8;
    localparam logic [2:0]  DECAY_RST      = 3'h7;
    localparam logic [1:0]  OFF_RST        = 2'h1;
    localparam logic [1:0]  RIPPLE_RST     = 2'h0;
    localparam logic [7:0]  FS_RST         = 8'hFF;
    localparam logic [7:0]  HOLD_RST       = 8'h80;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    localparam logic [1:0]  STRAP_LOW      = 2'h0;
    localparam logic [1:0]  STRAP_HIGH     = 2'h1;
    localparam logic [1:0]  STRAP_HIZ      = 2'h2;

    // gate order {hs1, ls1, hs2, ls2}
    localparam logic [3:0]  GATE_OFF       = 4'h0;
    localparam logic [3:0]  GATE_FWD       = 4'h9;
    localparam logic [3:0]  GATE_REV       = 4'h6;
    localparam logic [3:0]  GATE_SLOW      = 4'h5;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_DRIVE = 2'h1,
        ST_FAST  = 2'h3,
        ST_SLOW  = 2'h2
    } scdc_state_t;

    typedef enum logic [2:0] {
        MODE_SLOW   = 3'h0,
        MODE_MIX30  = 3'h4,
        MODE_MIX60  = 3'h5,
        MODE_DYN    = 3'h6,
        MODE_RIPPLE = 3'h7
    } scdc_mode_t;

endpackage

// *** hdl/scdc_tmr_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface scdc_tmr_if;
    logic        start;
    logic [10:0] length;
    logic [10:0] count;
    logic        expired;
    modport ctl (output start, output length, input count, input expired);
    modport tmr (input start, input length, output count, output expired);
endinterface
`default_nettype wire

// *** hdl/scdc_off_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module scdc_off_timer
    import scdc_pkg::*;
(
    input  wire logic i_ref_clk,
    input  wire logic i_reset_n,
    scdc_tmr_if.tmr   tmr
);
    logic [10:0] count_r;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
            count_r <= 11'h000;
        else if (tmr.start)
            count_r <= 11'h000;
        else if (count_r != 11'h7FF)
            count_r <= count_r + 11'h001;
    end

    assign tmr.count   = count_r;
    assign tmr.expired = ({1'b0, count_r} + 12'h001) >= {1'b0, tmr.length};
endmodule
`default_nettype wire

// *** hdl/scdc_top.sv ***
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module scdc_top
    import scdc_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset_n,
    input  wire logic [7:0]  i_s_axi_awaddr,
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    output logic [1:0]       o_s_axi_bresp,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    input  wire logic [7:0]  i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    output logic [31:0]      o_s_axi_rdata,
    output logic [1:0]       o_s_axi_rresp,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready,
    input  wire logic        i_strap_mode,
    input  wire logic [1:0]  i_chop_strap_pin_a,
    input  wire logic [1:0]  i_chop_strap_pin_b,
    input  wire logic [1:0]  i_off_strap_pin,
    input  wire logic [11:0] i_ext_ref_mv,
    input  wire logic        i_trip_threshold,
    input  wire logic        i_valley_threshold,
    input  wire logic        i_near_zero,
    input  wire logic        i_step_falling,
    output logic [3:0]       o_gate,
    output logic [11:0]      o_full_scale_ref_mv,
    output logic [11:0]      o_holding_ref_mv,
    output logic [1:0]       o_valley_ripple_select,
    output logic [2:0]       o_valley_ripple_pct
);
    logic        int_ref_r, bridge_en_r;
    logic [2:0]  decay_sel_r;
    logic [1:0]  off_interval_select_r, valley_sel_r;
    logic [7:0]  full_scale_current_scale_r, holding_current_scale_r;
    logic [1:0]  strap_a_r, strap_b_r, strap_off_r;
    logic        aw_full_r, w_full_r, bvalid_r, rvalid_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r, rdata_r, wmask;
    logic [3:0]  w_strb_r;
    logic [1:0]  bresp_r, rresp_r;
    logic        wr_fire;
    scdc_state_t state_r, state_nxt;
    scdc_mode_t  mode;
    logic [10:0] off_len_nxt, off_len_r, fast_len_nxt, fast_len_r, drive_cnt_r;
    logic [3:0]  share_r, tenths;
    logic [14:0] fast_prod;
    logic        zero_seen_r, start_nxt, fast_done;
    logic [3:0]  gate_r, gate_nxt;
    logic [11:0] ref_mv;
    logic [20:0] fs_prod, hold_prod;
    logic [11:0] fs_ref_r, hold_ref_r;
    logic [1:0]  rip_sel;
    logic [2:0]  rip_pct_r;

    scdc_tmr_if tmr_if ();

    scdc_off_timer u_timer (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .tmr       (tmr_if.tmr)
    );

    // register slave: address and data are taken in either order
    assign o_s_axi_awready = !aw_full_r && !bvalid_r;
    assign o_s_axi_wready  = !w_full_r && !bvalid_r;
    assign o_s_axi_arready = !rvalid_r;
    assign o_s_axi_bvalid  = bvalid_r;
    assign o_s_axi_bresp   = bresp_r;
    assign o_s_axi_rvalid  = rvalid_r;
    assign o_s_axi_rresp   = rresp_r;
    assign o_s_axi_rdata   = rdata_r;
    assign wr_fire         = aw_full_r && w_full_r && !bvalid_r;
    assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end
        else
        begin
            if (o_s_axi_awready && i_s_axi_awvalid)
            begin
                aw_full_r <= 1'b1;
                aw_addr_r <= i_s_axi_awaddr;
            end
            if (o_s_axi_wready && i_s_axi_wvalid)
            begin
                w_full_r <= 1'b1;
                w_data_r <= i_s_axi_wdata;
                w_strb_r <= i_s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= (aw_addr_r == ADDR_CTRL || aw_addr_r == ADDR_SCALE ||
                              aw_addr_r == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_r && i_s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    // settings may be rewritten at any time; the chopper picks them up live
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            int_ref_r                  <= 1'b0;
            bridge_en_r                <= 1'b0;
            decay_sel_r                <= DECAY_RST;
            off_interval_select_r      <= OFF_RST;
            valley_sel_r               <= RIPPLE_RST;
            full_scale_current_scale_r <= FS_RST;
            holding_current_scale_r    <= HOLD_RST;
        end
        else if (wr_fire && aw_addr_r == ADDR_CTRL)
        begin
            if (w_strb_r[0])
            begin
                int_ref_r   <= w_data_r[CTRL_INT_REF];
                bridge_en_r <= w_data_r[CTRL_EN];
                decay_sel_r <= w_data_r[CTRL_DECAY_LSB +: 3];
            end
            if (wmask[CTRL_OFF_LSB + 1] && wmask[CTRL_OFF_LSB])
                off_interval_select_r <= w_data_r[CTRL_OFF_LSB +: 2];
            if (w_strb_r[1])
                valley_sel_r <= w_data_r[CTRL_RIP_LSB + 1 +: 2];
        end
        else if (wr_fire && aw_addr_r == ADDR_SCALE)
        begin
            if (w_strb_r[0])
                full_scale_current_scale_r <= w_data_r[SCALE_FS_LSB +: 8];
            if (w_strb_r[1])
                holding_current_scale_r <= w_data_r[SCALE_HOLD_LSB +: 8];
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end
        else if (!rvalid_r && i_s_axi_arvalid)
        begin
            rvalid_r <= 1'b1;
            rresp_r  <= RESP_OKAY;
            case (i_s_axi_araddr)
                ADDR_CTRL:   rdata_r <= {22'h000000, valley_sel_r, 1'b0, off_interval_select_r,
                                         decay_sel_r, bridge_en_r, int_ref_r};
                ADDR_SCALE:  rdata_r <= {16'h0000, holding_current_scale_r,
                                         full_scale_current_scale_r};
                ADDR_STATUS: rdata_r <= {17'h00000, zero_seen_r,
                                         holding_current_scale_r >= full_scale_current_scale_r,
                                         int_ref_r && !i_strap_mode, share_r, 3'h0, mode,
                                         state_r};
                default:
                begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_r && i_s_axi_rready)
            rvalid_r <= 1'b0;
    end

    // straps are sampled every cycle so a re-strapped board takes effect on the fly
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            strap_a_r   <= STRAP_LOW;
            strap_b_r   <= STRAP_HIGH;
            strap_off_r <= STRAP_HIGH;
        end
        else
        begin
            strap_a_r   <= i_chop_strap_pin_a;
            strap_b_r   <= i_chop_strap_pin_b;
            strap_off_r <= i_off_strap_pin;
        end
    end

    // reserved codes fall back to slow decay so the bridge stays regulated
    always_comb
    begin
        mode = MODE_SLOW;
        if (i_strap_mode)
        begin
            case ({strap_a_r, strap_b_r})
                {STRAP_HIZ, STRAP_HIGH}: mode = MODE_SLOW;
                {STRAP_HIGH, STRAP_LOW}: mode = MODE_MIX30;
                {STRAP_HIZ, STRAP_LOW}:  mode = MODE_MIX60;
                {STRAP_LOW, STRAP_LOW}:  mode = MODE_DYN;
                {STRAP_LOW, STRAP_HIGH}: mode = MODE_RIPPLE;
                default:                 mode = MODE_SLOW;
            endcase
        end
        else
        begin
            case (decay_sel_r)
                3'h4:    mode = MODE_MIX30;
                3'h5:    mode = MODE_MIX60;
                3'h6:    mode = MODE_DYN;
                3'h7:    mode = MODE_RIPPLE;
                default: mode = MODE_SLOW;
            endcase
        end
    end

    always_comb
    begin
        case (i_strap_mode ? strap_off_r : off_interval_select_r)
            2'h0:    off_len_nxt = OFF_CYC_00;
            2'h1:    off_len_nxt = OFF_CYC_01;
            2'h2:    off_len_nxt = OFF_CYC_10;
            default: off_len_nxt = OFF_CYC_11;
        endcase
        case (mode)
            MODE_MIX30: tenths = MIX30_TENTHS;
            MODE_MIX60: tenths = MIX60_TENTHS;
            MODE_DYN:   tenths = i_step_falling ? SHARE_MAX : share_r;
            default:    tenths = 4'h0;
        endcase
        fast_prod    = 15'(off_len_nxt) * 15'(tenths);
        fast_len_nxt = 11'(fast_prod / TENTHS_DIV);
    end

    assign tmr_if.start  = start_nxt;
    assign tmr_if.length = off_len_r;
    assign fast_done     = ({1'b0, tmr_if.count} + 12'h001) >= {1'b0, fast_len_r};

    always_comb
    begin
        state_nxt = state_r;
        start_nxt = 1'b0;
        case (state_r)
            ST_IDLE:
                if (bridge_en_r)
                    state_nxt = ST_DRIVE;
            ST_DRIVE:
                if (!bridge_en_r)
                    state_nxt = ST_IDLE;
                else if (i_trip_threshold)
                begin
                    start_nxt = 1'b1;
                    state_nxt = (fast_len_nxt == 11'h000) ? ST_SLOW : ST_FAST;
                end
            ST_FAST:
                if (!bridge_en_r)
                    state_nxt = ST_IDLE;
                else if (tmr_if.expired)
                    state_nxt = ST_DRIVE;
                else if (fast_done)
                    state_nxt = ST_SLOW;
            ST_SLOW:
                if (!bridge_en_r)
                    state_nxt = ST_IDLE;
                else if (mode == MODE_RIPPLE)
                begin
                    if (i_valley_threshold)
                        state_nxt = ST_DRIVE;
                end
                else if (tmr_if.expired)
                begin
                    if (i_trip_threshold)
                        start_nxt = 1'b1;
                    else
                        state_nxt = ST_DRIVE;
                end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_comb
    begin
        case (state_nxt)
            ST_DRIVE: gate_nxt = GATE_FWD;
            // a stale zero flag from the previous fast phase must not blank a new one
            ST_FAST:  gate_nxt = ((zero_seen_r && !start_nxt) || i_near_zero) ? GATE_OFF
                                                                           : GATE_REV;
            ST_SLOW:  gate_nxt = GATE_SLOW;
            default:  gate_nxt = GATE_OFF;
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            state_r     <= ST_IDLE;
            gate_r      <= GATE_OFF;
            zero_seen_r <= 1'b0;
            off_len_r   <= OFF_CYC_01;
            fast_len_r  <= 11'h000;
        end
        else
        begin
            state_r <= state_nxt;
            gate_r  <= gate_nxt;
            if (start_nxt)
            begin
                zero_seen_r <= 1'b0;
                off_len_r   <= off_len_nxt;
                fast_len_r  <= (state_r == ST_SLOW) ? 11'h000 : fast_len_nxt;
            end
            else if (state_r == ST_FAST && i_near_zero)
                zero_seen_r <= 1'b1;
        end
    end

    // a drive that trips almost at once means the current overshot the threshold
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            drive_cnt_r <= 11'h000;
            share_r     <= SHARE_RST;
        end
        else
        begin
            if (state_r != ST_DRIVE)
                drive_cnt_r <= 11'h000;
            else if (drive_cnt_r != 11'h7FF)
                drive_cnt_r <= drive_cnt_r + 11'h001;
            if (state_r == ST_DRIVE && start_nxt && mode == MODE_DYN)
            begin
                if (drive_cnt_r < DYN_SHORT_CYC && share_r != SHARE_MAX)
                    share_r <= share_r + 4'h1;
                else if (drive_cnt_r > DYN_LONG_CYC && share_r != 4'h0)
                    share_r <= share_r - 4'h1;
            end
        end
    end

    // sense gain division happens in the analog reference; only the voltage is formed here
    assign ref_mv    = (int_ref_r && !i_strap_mode) ? INT_REF_MV : i_ext_ref_mv;
    assign fs_prod   = 21'(ref_mv) * 21'({1'b0, full_scale_current_scale_r} + 9'h001);
    assign hold_prod = 21'(ref_mv) * 21'({1'b0, holding_current_scale_r} + 9'h001);
    assign rip_sel   = i_strap_mode ? strap_off_r : valley_sel_r;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            fs_ref_r   <= 12'h000;
            hold_ref_r <= 12'h000;
            rip_pct_r  <= RIPPLE_PCT_00;
        end
        else
        begin
            fs_ref_r   <= i_strap_mode ? ref_mv : fs_prod[19:8];
            hold_ref_r <= i_strap_mode ? ref_mv : hold_prod[19:8];
            case (rip_sel)
                2'h0:    rip_pct_r <= RIPPLE_PCT_00;
                2'h1:    rip_pct_r <= RIPPLE_PCT_01;
                2'h2:    rip_pct_r <= RIPPLE_PCT_10;
                default: rip_pct_r <= RIPPLE_PCT_11;
            endcase
        end
    end

    assign o_gate                 = gate_r;
    assign o_full_scale_ref_mv    = fs_ref_r;
    assign o_holding_ref_mv       = hold_ref_r;
    assign o_valley_ripple_select = valley_sel_r;
    assign o_valley_ripple_pct    = rip_pct_r;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    int_ref_use_a: assert property (int_ref_r && !i_strap_mode && $stable(full_scale_current_scale_r)
        |=> o_full_scale_ref_mv == 12'((21'(INT_REF_MV) * 21'({1'b0, full_scale_current_scale_r}
        + 9'h001)) >> 8)) else $error("internal reference not used");
    trip_exit_a: assert property (state_r == ST_DRIVE && bridge_en_r && i_trip_threshold
        |=> state_r inside {ST_FAST, ST_SLOW}) else $error("trip did not end drive");
    drive_hold_a: assert property (state_r == ST_DRIVE && bridge_en_r && !i_trip_threshold
        |=> state_r == ST_DRIVE && o_gate == GATE_FWD) else $error("drive left early");
    fast_gate_a: assert property (state_r == ST_FAST && !zero_seen_r && !$past(i_near_zero)
        |-> o_gate == GATE_REV) else $error("fast decay not reversed");
    slow_gate_a: assert property (state_r == ST_SLOW |-> o_gate == GATE_SLOW)
        else $error("slow decay gates wrong");
    mix30_map_a: assert property (!i_strap_mode && decay_sel_r == 3'h4 |-> mode == MODE_MIX30)
        else $error("decay code map wrong");
    strap_map_a: assert property (i_strap_mode && i_chop_strap_pin_a == STRAP_LOW &&
        i_chop_strap_pin_b == STRAP_HIGH |=> mode == MODE_RIPPLE)
        else $error("strap map wrong");
    slow_extend_a: assert property (state_r == ST_SLOW && bridge_en_r && mode != MODE_RIPPLE &&
        tmr_if.expired && i_trip_threshold |=> state_r == ST_SLOW && tmr_if.count == 11'h000)
        else $error("slow decay not extended");
    mix_split_a: assert property (state_r == ST_FAST && bridge_en_r && mode == MODE_MIX30 &&
        $past(state_r) == ST_DRIVE |-> fast_len_r == 11'((15'(off_len_r) * 15'h0003) / 15'h000A))
        else $error("mixed fast share wrong");
    dyn_raise_a: assert property (state_r == ST_DRIVE && start_nxt && mode == MODE_DYN &&
        drive_cnt_r < DYN_SHORT_CYC && share_r < SHARE_MAX |=> share_r == $past(share_r) + 4'h1)
        else $error("dynamic share not raised");
    dyn_fall_a: assert property (state_r == ST_DRIVE && start_nxt && mode == MODE_DYN &&
        i_step_falling |=> fast_len_r == off_len_r) else $error("falling step not fast");
    valley_wait_a: assert property (state_r == ST_SLOW && bridge_en_r && mode == MODE_RIPPLE &&
        !i_valley_threshold |=> state_r == ST_SLOW) else $error("ripple left early");
    off_len_a: assert property (state_r == ST_DRIVE && start_nxt && !i_strap_mode &&
        off_interval_select_r == 2'h3 |=> off_len_r == 11'h578) else $error("off-time wrong");

    mix_to_slow_c: cover property (state_r == ST_FAST ##1 state_r == ST_SLOW);
    extend_c:      cover property (state_r == ST_SLOW && start_nxt);
    valley_c:      cover property (mode == MODE_RIPPLE && state_r == ST_SLOW ##1 state_r == ST_DRIVE);
    dyn_up_c:      cover property (share_r == SHARE_RST ##1 share_r == SHARE_RST + 4'h1);
endmodule
`default_nettype wire

// *** sim/scdc_motor.sv ***
`timescale 1ns/1ps
`default_nettype none
module scdc_motor
(
    input  wire logic       i_ref_clk,
    input  wire logic [3:0] i_gate,
    output logic            o_trip,
    output logic            o_valley,
    output logic            o_near_zero
);
    logic [3:0] gate_r  = 4'h0;
    logic [3:0] dwell_r = 4'h0;
    // dwell saturates so a long slow phase never wraps back under the valley
    always_ff @(posedge i_ref_clk)
    begin
        gate_r  <= i_gate;
        dwell_r <= (i_gate != gate_r) ? 4'h0 : dwell_r + {3'h0, dwell_r != 4'hF};
    end
    assign o_trip      = (gate_r == 4'h9) && (dwell_r > 4'h7);
    assign o_near_zero = (gate_r == 4'h6) && (dwell_r > 4'h7);
    assign o_valley    = (gate_r == 4'h5) && (dwell_r > 4'h7);
endmodule
`default_nettype wire

// *** sim/scdc_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module scdc_top_bench;
    import scdc_pkg::*;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("BAD %0t %h mismatch", $time, g); end end
    logic clk = 0, rst_n = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, strap = 0, fall = 0;
    logic [1:0] pa = STRAP_LOW, pb = STRAP_HIGH, brsp, bs, rsel;
    logic [7:0] aw_a = 0, ar_a = 0;
    logic [31:0] w_d = 0, rv, rdat;
    logic [11:0] ext_mv = 0, fs_mv, hold_mv;
    logic [1:0] rs, rrsp;
    logic aw_k, w_k, b_k, ar_k, r_k, trip, valley, nz;
    logic [3:0] gate;
    logic [2:0] pct;
    int errors = 0, samples_checked = 0, n;
    scdc_top dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_s_axi_awaddr(aw_a),
        .i_s_axi_awvalid(aw_v), .o_s_axi_awready(aw_k), .i_s_axi_wdata(w_d),
        .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(w_v), .o_s_axi_wready(w_k), .o_s_axi_bresp(brsp),
        .o_s_axi_bvalid(b_k), .i_s_axi_bready(b_r), .i_s_axi_araddr(ar_a),
        .i_s_axi_arvalid(ar_v), .o_s_axi_arready(ar_k), .o_s_axi_rdata(rdat),
        .o_s_axi_rresp(rrsp), .o_s_axi_rvalid(r_k), .i_s_axi_rready(r_r), .i_strap_mode(strap),
        .i_chop_strap_pin_a(pa), .i_chop_strap_pin_b(pb),
        .i_off_strap_pin(STRAP_LOW), .i_ext_ref_mv(ext_mv), .i_trip_threshold(trip),
        .i_valley_threshold(valley), .i_near_zero(nz), .i_step_falling(fall), .o_gate(gate),
        .o_full_scale_ref_mv(fs_mv), .o_holding_ref_mv(hold_mv),
        .o_valley_ripple_select(rsel), .o_valley_ripple_pct(pct));
    scdc_motor motor (.i_ref_clk(clk), .i_gate(gate), .o_trip(trip), .o_valley(valley),
        .o_near_zero(nz));
    initial forever #12.5 clk = ~clk;
    // handshakes are judged at the falling edge; inputs only move at rising edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic done, ta, tw;
        done = 0;
        aw_a <= a;
        w_d <= d;
        aw_v <= 1;
        w_v <= 1;
        b_r <= 1;
        while (!done)
        begin
            @(negedge clk);
            ta = aw_k;
            tw = w_k;
            done = b_k;
            bs = brsp;
            @(posedge clk);
            if (ta) aw_v <= 0;
            if (tw) w_v <= 0;
        end
        b_r <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic done, ta;
        done = 0;
        ar_a <= a;
        ar_v <= 1;
        r_r <= 1;
        while (!done)
        begin
            @(negedge clk);
            ta = ar_k;
            done = r_k;
            rv = rdat;
            rs = rrsp;
            @(posedge clk);
            if (ta) ar_v <= 0;
        end
        r_r <= 0;
    endtask
    task automatic span(input logic [3:0] a, input logic [3:0] b);
        n = 0;
        for (int k = 0; k < 4000 && gate !== a; k++) @(negedge clk);
        while ((gate === a || gate === b) && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
    endtask
    task automatic stop_test;
        $display("checks %0d bad %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // only codes 0, 4, 5, 6, 7 are written and holding stays below full scale
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        rd(ADDR_CTRL);
        `CHK(rv, 32'h0000003C)
        rd(ADDR_SCALE);
        `CHK(rv, 32'h000080FF)
        rd(8'h0C);
        `CHK(rs, RESP_SLVERR)
        `CHK(pct, 3'h1)
        ext_mv <= 12'h800;
        repeat (3) @(posedge clk);
        `CHK(fs_mv, 12'h800)
        `CHK(hold_mv, 12'h408)
        wr(ADDR_CTRL, 32'h3D);
        repeat (3) @(posedge clk);
        `CHK(fs_mv, INT_REF_MV)
        `CHK(hold_mv, 12'h67E)
        $display("refs done");
        wr(ADDR_CTRL, 32'h02);
        span(GATE_SLOW, GATE_SLOW);
        `CHK(n, 360)
        `CHK(gate, GATE_FWD)
        wr(ADDR_CTRL, 32'h62);
        span(GATE_FWD, GATE_FWD);
        span(GATE_SLOW, GATE_SLOW);
        `CHK(n, 1400)
        $display("slow done");
        wr(ADDR_CTRL, 32'h12);
        span(GATE_REV, GATE_OFF);
        `CHK(n, 108)
        wr(ADDR_CTRL, 32'h16);
        span(GATE_FWD, GATE_FWD);
        span(GATE_REV, GATE_OFF);
        `CHK(n, 216)
        wr(ADDR_CTRL, 32'h21E);
        `CHK(bs, RESP_OKAY)
        span(GATE_FWD, GATE_FWD);
        span(GATE_SLOW, GATE_SLOW);
        `CHK(n < 40, 1'b1)
        `CHK(rsel, 2'h2)
        `CHK(pct, 3'h4)
        wr(8'h0C, 32'h0);
        `CHK(bs, RESP_SLVERR)
        $display("decay done");
        wr(ADDR_CTRL, 32'h1A);
        span(GATE_FWD, GATE_FWD);
        span(GATE_REV, GATE_OFF);
        span(GATE_FWD, GATE_FWD);
        rd(ADDR_STATUS);
        `CHK(rv[11:8] > 4'h3, 1'b1)
        fall <= 1;
        span(GATE_FWD, GATE_FWD);
        span(GATE_REV, GATE_OFF);
        `CHK(n, 360)
        fall <= 0;
        strap <= 1;
        pa <= STRAP_HIGH;
        pb <= STRAP_LOW;
        span(GATE_FWD, GATE_FWD);
        span(GATE_FWD, GATE_FWD);
        span(GATE_REV, GATE_OFF);
        `CHK(n, 108)
        `CHK(fs_mv, 12'h800)
        `CHK(pct, 3'h1)
        pa <= STRAP_LOW;
        pb <= STRAP_HIGH;
        repeat (3) @(posedge clk);
        $display("dyn strap done");
        stop_test;
    end
    initial
    begin
        #(25 * 20000);
        errors++;
        stop_test;
    end
endmodule
`default_nettype wire
